// ---- tb.sv ----
// Self-checking bench for the two-wire serial channel.
// Assumes the far-end model resolves both open-drain lines.
`timescale 1ns/100ps
module tb;
    import tws_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] e; logic err;} tws_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq, scl, sda, scl_oe, sda_oe;
    logic [7:0] paddr, cap;
    logic [31:0] pwdata, prdata, rd;
    int bad_count = 0, comparisons = 0, irq_count = 0;
    tws_row_t rows[6] = '{'{ADDR_CTRL, CTRL_RST, 0}, '{ADDR_TRIG, 0, 0}, '{ADDR_SHIFT, SHIFT_RST, 0},
        '{ADDR_MATCH, MATCH_RST, 0}, '{ADDR_STAT, 0, 0}, '{8'h14, 0, 1}};
    tws_channel tws_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shift_clock_pin_in(scl), .shift_clock_pin_out(), .shift_clock_pin_oe(scl_oe),
        .serial_bus_pin_a_in(sda), .serial_bus_pin_a_out(), .serial_bus_pin_a_oe(sda_oe),
        .serial_bus_pin_b_in(1'b1), .serial_bus_pin_b_out(), .serial_bus_pin_b_oe(), .transfer_irq(irq));
    tws_far_end tws_far_end_inst (.dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe), .scl(scl), .sda(sda));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, event counter and wire capture
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (irq === 1'b1) irq_count++;
    always @(posedge scl) cap <= {cap[6:0], sda};
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task print_verdict();
        $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog
    initial begin
        #100000;
        bad_count++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0);
            chk(rd, rows[i].e);
            chk(err, rows[i].err);
        end
        $display("register map test done");
        apb(1, ADDR_SHIFT, 32'h12);
        apb(1, ADDR_CTRL, 32'h8A);
        apb(0, ADDR_STAT, 0);
        chk(rd[STAT_BUSY], 0);
        chk(scl, 1);
        apb(1, ADDR_CTRL, 32'h88);
        chk(scl, 0);
        apb(1, ADDR_CTRL, 32'h8A);
        apb(1, ADDR_MATCH, 32'hA5);
        apb(1, ADDR_SHIFT, 32'hA5);
        do apb(0, ADDR_STAT, 0); while (rd[STAT_DONE] !== 1'b1);
        chk(cap, 8'hA5);
        chk(irq_count, 1);
        apb(0, ADDR_SHIFT, 0);
        chk(rd, 32'hA5);
        apb(0, ADDR_CTRL, 0);
        chk(rd, 32'hCA);
        apb(1, ADDR_TRIG, 32'h2);
        chk(sda, 0);
        apb(1, ADDR_TRIG, 32'h1);
        chk(sda, 1);
        $display("two-wire transfer test done");
        apb(1, ADDR_CTRL, 32'hB1);
        apb(1, ADDR_MATCH, 32'h84);
        tws_far_end_inst.start_cond();
        tws_far_end_inst.send_byte(8'h20);
        tws_far_end_inst.stop_cond();
        repeat (5) @(posedge pclk);
        apb(0, ADDR_STAT, 0);
        chk(rd[STAT_SEL], 0);
        chk(irq_count, 1);
        tws_far_end_inst.start_cond();
        tws_far_end_inst.send_byte(8'h84);
        repeat (5) @(posedge pclk);
        chk(tws_far_end_inst.ack_seen, 1);
        apb(0, ADDR_STAT, 0);
        chk(rd & 32'h1C, 32'h0C);
        apb(0, ADDR_TRIG, 0);
        chk(rd[TRIG_COMMAND_DETECT], 1);
        chk(irq_count, 2);
        apb(1, ADDR_SHIFT, 32'hFF);
        tws_far_end_inst.stop_cond();
        repeat (5) @(posedge pclk);
        apb(0, ADDR_TRIG, 0);
        chk(rd[TRIG_STOPD], 1);
        apb(0, ADDR_STAT, 0);
        chk(rd[STAT_SEL], 0);
        $display("bus mode slave test done");
        // Mid-run reset: outputs quiet, control and shift registers back to reset values
        presetn <= 1'b0;
        @(posedge pclk);
        chk({scl_oe, sda_oe, irq, pready}, 0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, ADDR_CTRL, 0);
        chk(rd, CTRL_RST);
        apb(0, ADDR_SHIFT, 0);
        chk(rd, SHIFT_RST);
        $display("reset test done");
        print_verdict();
    end
endmodule

// ---- tws_channel.sv ----
// Two-wire serial channel: 8-bit shift engine, slave bus mode and APB registers.
// Assumes open-drain pins with external pull-ups and an APB master on pclk.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/100ps

// Summary of operation
// RQ1: Transfers move eight bits, one bit per serial clock cycle.
// RQ2: The shift register advances on each falling serial clock edge.
// RQ3: Transmit data leaves the selected data pin most significant bit first.
// RQ4: The data pin level is captured on each rising serial clock edge.
// RQ5: After eight bits shifting stops and the done flag is set.
// RQ6: Software loads all ones before receiving so the data line is released.
// RQ7: Release trigger sets the output latch, command trigger clears it; both self-clear.
// RQ8: With internal clock, the idle clock pin level follows the port latch bit.
// RQ9: A shift register write starts only when enabled and the clock is high or stopped.
// RQ10: A write made while the channel is disabled never starts a transfer later.
// RQ11: The real bus level shifts back in, exposing transmit errors.
// RQ12: The match flag reads one when shift register equals the match value.
// RQ13: Data falling while clock is high is a start condition.
// RQ14: After a start the 7-bit address is compared; a match selects until start or stop.
// RQ15: The bit after the address gives direction: 0 master sends, 1 slave sends.
// RQ16: The receiver acknowledges every received byte.
// RQ17: A master receiver withholds acknowledge on its last byte.
// RQ18: Senders check acknowledge; a missing one ends the transfer.
// RQ19: Data rising while clock is high is a stop condition.
// RQ20: With wake-up on, only a matching address raises an interrupt.
// RQ21: The master supplies the clock throughout a transfer.
// RQ22: Only the master creates start, address and stop.
// RQ23: A slave not ready holds the clock low; the master waits for release.
// RQ24: Wake-up interrupts only for the address after a start; otherwise every transfer.
// RQ25: The data line is pulled low only for a zero bit, released otherwise.
module tws_channel import tws_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial clock pin
    input wire logic shift_clock_pin_in,
    output logic shift_clock_pin_out,
    output logic shift_clock_pin_oe,
    // Data pin a
    input wire logic serial_bus_pin_a_in,
    output logic serial_bus_pin_a_out,
    output logic serial_bus_pin_a_oe,
    // Data pin b
    input wire logic serial_bus_pin_b_in,
    output logic serial_bus_pin_b_out,
    output logic serial_bus_pin_b_oe,
    // Event
    output logic transfer_irq
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] slave_match_value;
        logic [7:0] serial_shift_register;
        tws_shift_t st;
        logic [3:0] cnt;
        logic [DIV_W-1:0] div;
        logic sck;
        logic rx_bit;
        logic rx_valid;
        logic addr_phase;
        logic selected;
        logic dir;
        logic ack_drive;
        logic output_latch_bit;
        logic transfer_done_flag;
        logic address_match_flag;
        logic command_detect;
        logic stop_detect;
        logic ack_detect;
        logic irq;
        logic sda_oe_a;
        logic sda_oe_b;
        logic scl_oe;
        logic pin_low;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tws_core_t;

    tws_core_t s;
    tws_core_t next_s;
    tws_line_if ln();

    logic use_int;
    logic div_hit;
    logic rise_ev;
    logic fall_ev;
    logic sda_in;
    logic apb_wr;
    logic shift_wr;
    logic shift_ok;
    logic [7:0] shifted;

    ////////////////////////////////////////////////////////////////////////////
    // Level driven onto the data line by the engine state
    function automatic logic line_bit(input tws_core_t c);
        logic tx;
        tx = !c.ctrl[CTRL_I2C] || (c.selected && c.dir && !c.addr_phase);
        unique case (c.st)
            SH_DATA: line_bit = tx ? c.serial_shift_register[7] : 1'b1;
            SH_ACK: line_bit = !c.ack_drive;
            SH_IDLE, SH_HOLD: line_bit = c.output_latch_bit;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and bus condition detector
    tws_sync u_sync (.pclk(pclk), .presetn(presetn),
        .pins({serial_bus_pin_b_in, serial_bus_pin_a_in, shift_clock_pin_in}), .ln(ln.sync));
    tws_cond u_cond (
        .pclk(pclk),
        .presetn(presetn),
        .ln(ln.cond)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock edges, sampled data and access decode
    assign ln.pin_b = s.ctrl[CTRL_PINB];
    assign use_int = s.ctrl[CTRL_INTCLK] && !s.ctrl[CTRL_I2C];
    assign div_hit = use_int && (s.st != SH_IDLE) && (s.div == SCLK_HALF_LAST);
    assign rise_ev = use_int ? (div_hit && !s.sck) : ln.rise[LN_SCL];
    assign fall_ev = use_int ? (div_hit && s.sck) : ln.fall[LN_SCL];
    assign sda_in = s.ctrl[CTRL_PINB] ? ln.lvl[LN_SDA_B] : ln.lvl[LN_SDA_A];
    assign apb_wr = psel && penable && pwrite && s.pready;
    assign shift_wr = apb_wr && (paddr == ADDR_SHIFT);
    assign shift_ok = s.ctrl[CTRL_EN] && (s.ctrl[CTRL_I2C] ? (s.st == SH_HOLD) :
                      ((s.st == SH_IDLE) && (use_int || ln.lvl[LN_SCL])));
    assign shifted = {s.serial_shift_register[6:0], s.rx_bit};

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_s = s;
        next_s.pready = 1'b0;
        next_s.pslverr = 1'b0;
        next_s.irq = 1'b0;

        // APB read data and answer, one wait state
        if (psel && penable && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.prdata = '0;
            unique case (paddr)
                ADDR_CTRL: next_s.prdata[7:0] = {s.ctrl[7], s.address_match_flag, s.ctrl[5:0]};
                ADDR_TRIG: next_s.prdata[7:0] = {3'h0, s.ack_detect, s.command_detect, s.stop_detect, 2'h0};
                ADDR_SHIFT: next_s.prdata[7:0] = s.serial_shift_register;
                ADDR_MATCH: next_s.prdata[7:0] = s.slave_match_value;
                ADDR_STAT: next_s.prdata[7:0] = {3'h0, s.dir, s.selected, s.st == SH_HOLD,
                                                 s.st != SH_IDLE, s.transfer_done_flag};
                default: next_s.pslverr = 1'b1;
            endcase
        end

        // Register writes; clears come before hardware sets
        if (apb_wr) begin
            unique case (paddr)
                ADDR_CTRL: next_s.ctrl = pwdata[7:0] & CTRL_WMASK;
                ADDR_MATCH: next_s.slave_match_value = pwdata[7:0];
                ADDR_STAT: begin
                    if (pwdata[STAT_DONE]) next_s.transfer_done_flag = 1'b0;
                end
                ADDR_TRIG: begin
                    if (pwdata[TRIG_STOPD]) next_s.stop_detect = 1'b0;
                    if (pwdata[TRIG_COMMAND_DETECT]) next_s.command_detect = 1'b0;
                    if (pwdata[TRIG_ACKD]) next_s.ack_detect = 1'b0;
                    if (s.st == SH_IDLE && s.ctrl[CTRL_EN]) begin
                        if (pwdata[TRIG_REL]) next_s.output_latch_bit = 1'b1; // RQ7
                        if (pwdata[TRIG_CMD]) next_s.output_latch_bit = 1'b0; // RQ7
                    end
                end
                default: begin
                end
            endcase
        end

        // Transfer start on shift register write
        if (shift_wr && shift_ok) begin // RQ9 RQ10
            next_s.serial_shift_register = pwdata[7:0];
            next_s.st = SH_DATA;
            next_s.cnt = '0;
            next_s.rx_valid = 1'b0;
            next_s.div = '0;
            next_s.sck = 1'b1;
        end

        // Internal clock divider, runs only during a transfer
        if (use_int && s.st != SH_IDLE) begin
            next_s.div = div_hit ? '0 : s.div + 1'b1;
            if (div_hit) next_s.sck = !s.sck;
        end

        // Shift engine
        unique case (s.st)
            SH_IDLE, SH_HOLD: begin
            end
            SH_DATA: begin
                if (rise_ev) begin
                    next_s.rx_bit = sda_in; // RQ4 RQ11
                    next_s.rx_valid = 1'b1;
                end
                if (fall_ev && s.rx_valid) begin
                    next_s.serial_shift_register = shifted; // RQ2
                    next_s.rx_valid = 1'b0;
                    next_s.cnt = s.cnt + 1'b1;
                    if (s.cnt == LAST_BIT) begin // RQ1
                        next_s.address_match_flag = (shifted == s.slave_match_value); // RQ12
                        if (!s.ctrl[CTRL_I2C]) begin
                            next_s.st = SH_IDLE; // RQ5
                            next_s.transfer_done_flag = 1'b1; // RQ5
                            next_s.irq = 1'b1;
                        end else if (s.addr_phase) begin
                            next_s.st = SH_ACK;
                            next_s.selected = (shifted[7:1] == s.slave_match_value[7:1]); // RQ14
                            next_s.dir = shifted[0]; // RQ15
                            next_s.ack_drive = next_s.selected && s.ctrl[CTRL_ACKEN]; // RQ16
                        end else begin
                            next_s.st = SH_ACK;
                            next_s.ack_drive = s.selected && !s.dir && s.ctrl[CTRL_ACKEN]; // RQ16
                        end
                    end
                end
            end
            SH_ACK: begin
                if (rise_ev && s.selected && s.dir && !s.addr_phase) begin
                    next_s.ack_detect = !sda_in; // RQ18
                end
                if (fall_ev) begin
                    next_s.transfer_done_flag = 1'b1;
                    next_s.ack_drive = 1'b0;
                    next_s.addr_phase = 1'b0;
                    next_s.irq = s.ctrl[CTRL_WAKE] ? (s.addr_phase && s.selected) : 1'b1; // RQ20 RQ24
                    if (s.selected && s.dir && !s.addr_phase && !s.ack_detect) begin
                        next_s.selected = 1'b0; // RQ17 RQ18
                        next_s.st = SH_IDLE;
                    end else begin
                        next_s.st = s.selected ? SH_HOLD : SH_IDLE; // RQ23
                    end
                end
            end
        endcase

        // Bus conditions override the engine
        if (s.ctrl[CTRL_I2C] && ln.start_cond) begin
            next_s.command_detect = 1'b1; // RQ13
            next_s.st = SH_DATA;
            next_s.addr_phase = 1'b1; // RQ14
            next_s.selected = 1'b0;
            next_s.ack_drive = 1'b0;
            next_s.cnt = '0;
            next_s.rx_valid = 1'b0;
        end
        if (s.ctrl[CTRL_I2C] && ln.stop_cond) begin
            next_s.stop_detect = 1'b1; // RQ19
            next_s.st = SH_IDLE;
            next_s.addr_phase = 1'b0;
            next_s.selected = 1'b0;
            next_s.ack_drive = 1'b0;
        end

        // Disabled channel: engine stopped, command detect, stop detect and match flags cleared
        if (!next_s.ctrl[CTRL_EN]) begin
            next_s.st = SH_IDLE;
            next_s.address_match_flag = 1'b0;
            next_s.command_detect = 1'b0;
            next_s.stop_detect = 1'b0;
            next_s.selected = 1'b0;
            next_s.addr_phase = 1'b0;
            next_s.ack_drive = 1'b0;
        end
        if (next_s.st == SH_IDLE) begin
            next_s.sck = 1'b1;
            next_s.div = '0;
        end

        // Open-drain pin enables, low only for a zero bit
        next_s.sda_oe_a = next_s.ctrl[CTRL_EN] && !next_s.ctrl[CTRL_PINB] && !line_bit(next_s); // RQ25 RQ3
        next_s.sda_oe_b = next_s.ctrl[CTRL_EN] && next_s.ctrl[CTRL_PINB] && !line_bit(next_s); // RQ25 RQ3
        if (next_s.ctrl[CTRL_INTCLK] && !next_s.ctrl[CTRL_I2C]) begin
            next_s.scl_oe = (next_s.st == SH_IDLE) ? !next_s.ctrl[CTRL_CLKLAT] : !next_s.sck; // RQ8
        end else begin
            next_s.scl_oe = (next_s.st == SH_HOLD); // RQ23
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.ctrl <= CTRL_RST;
            s.slave_match_value <= MATCH_RST;
            s.serial_shift_register <= SHIFT_RST;
            s.output_latch_bit <= 1'b1;
            s.sck <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign shift_clock_pin_out = s.pin_low;
    assign shift_clock_pin_oe = s.scl_oe;
    assign serial_bus_pin_a_out = s.pin_low;
    assign serial_bus_pin_a_oe = s.sda_oe_a;
    assign serial_bus_pin_b_out = s.pin_low;
    assign serial_bus_pin_b_oe = s.sda_oe_b;
    assign transfer_irq = s.irq;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_last_fall;
        s.st == SH_DATA && fall_ev && s.rx_valid && s.cnt == LAST_BIT;
    endsequence
    sequence s_hold_two;
        s.st == SH_HOLD [*2];
    endsequence

    a_eight_bits_done: assert property (s_last_fall and !s.ctrl[CTRL_I2C] && !ln.start_cond
        |=> s.transfer_done_flag && s.st == SH_IDLE && transfer_irq) // RQ5
        else $error("byte end did not stop and flag done");
    a_shift_on_fall: assert property (s.st == SH_DATA && !(fall_ev && s.rx_valid) && !shift_wr
        |=> $stable(s.serial_shift_register)) // RQ2
        else $error("shift register moved without a falling edge");
    a_capture_rise: assert property (s.st == SH_DATA && rise_ev && s.ctrl[CTRL_EN] && !ln.start_cond
        |=> s.rx_bit == $past(sda_in) && s.rx_valid) // RQ4
        else $error("rising edge did not capture bus level");
    a_msb_driven: assert property (s.st == SH_DATA && !s.ctrl[CTRL_I2C] && !s.ctrl[CTRL_PINB] && s.ctrl[CTRL_EN]
        |-> serial_bus_pin_a_oe == !s.serial_shift_register[7]) // RQ3
        else $error("data pin does not show the shift register msb");
    a_start_gated: assert property (shift_wr && !s.ctrl[CTRL_EN] |=> s.st == SH_IDLE) // RQ10
        else $error("transfer started while disabled");
    a_match_result: assert property (s_last_fall and s.ctrl[CTRL_EN] && !ln.start_cond && !ln.stop_cond
        |=> s.address_match_flag == (s.serial_shift_register == s.slave_match_value)) // RQ12
        else $error("match flag disagrees with shift register");
    a_start_seen: assert property (ln.start_cond && s.ctrl[CTRL_I2C] && s.ctrl[CTRL_EN] && !(apb_wr && paddr == ADDR_CTRL)
        |=> s.command_detect && s.addr_phase && s.st == SH_DATA) // RQ13
        else $error("start condition not taken");
    a_stop_seen: assert property (ln.stop_cond && s.ctrl[CTRL_I2C] && s.ctrl[CTRL_EN]
        |=> !s.selected && s.st == SH_IDLE) // RQ19
        else $error("stop condition did not release the slave");
    a_wake_filter: assert property (s.st == SH_ACK && fall_ev && s.ctrl[CTRL_WAKE] && !(s.addr_phase && s.selected)
        |=> !transfer_irq) // RQ20
        else $error("interrupt raised without address match");
    a_wait_hold: assert property (s_hold_two and s.ctrl[CTRL_I2C] |-> shift_clock_pin_oe) // RQ23
        else $error("clock line not held during wait");
    a_release_trig: assert property (apb_wr && paddr == ADDR_TRIG && pwdata[TRIG_REL] && !pwdata[TRIG_CMD]
        && s.st == SH_IDLE && s.ctrl[CTRL_EN] && !ln.start_cond ##1 !(apb_wr && paddr == ADDR_CTRL)
        |-> s.output_latch_bit) // RQ7
        else $error("release trigger did not set the output latch");
endmodule

// ---- tws_cond.sv ----
// Start and stop condition detector on the selected data line.
// Assumes synchronised levels and edges from the synchroniser.
`timescale 1ns/100ps
module tws_cond import tws_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Line view
    tws_line_if.cond ln
);
    typedef struct packed {
        logic start_cond;
        logic stop_cond;
    } tws_cond_t;

    tws_cond_t s;
    tws_cond_t next_s;
    logic sda_fall;
    logic sda_rise;

    assign sda_fall = ln.pin_b ? ln.fall[LN_SDA_B] : ln.fall[LN_SDA_A];
    assign sda_rise = ln.pin_b ? ln.rise[LN_SDA_B] : ln.rise[LN_SDA_A];

    ////////////////////////////////////////////////////////////////////////////
    // Data edge while the clock line stays high
    always_comb begin
        next_s.start_cond = ln.lvl[LN_SCL] && sda_fall; // RQ13
        next_s.stop_cond = ln.lvl[LN_SCL] && sda_rise; // RQ19
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign ln.start_cond = s.start_cond;
    assign ln.stop_cond = s.stop_cond;
endmodule

// ---- tws_far_end.sv ----
// Far-side model: pull-ups on both lines and one bus master.
// Assumes the channel's enables pull a line low while high.
`timescale 1ns/100ps
module tws_far_end (
    // Channel enables
    input wire logic dut_scl_oe,
    input wire logic dut_sda_oe,
    // Resolved lines
    output logic scl,
    output logic sda
);
    logic m_scl = 1'b1;
    logic m_sda = 1'b1;
    logic ack_seen = 1'b0;
    // Wired-and with pull-ups, a released line reads high
    assign scl = !(dut_scl_oe || !m_scl);
    assign sda = !(dut_sda_oe || !m_sda);
    // One clock pulse, waiting while a slave stretches the clock
    task pulse();
        #24 m_scl = 1'b1;
        wait (scl === 1'b1);
        #24 m_scl = 1'b0;
    endtask
    // Data falls under a high clock
    task start_cond();
        #24 m_sda = 1'b0;
        #24 m_scl = 1'b0;
    endtask
    // Address or data byte, then the acknowledge clock
    task send_byte(input logic [7:0] b);
        // Data moves only well after the clock has fallen, never as a false start or stop
        for (int i = 7; i >= 0; i--) begin
            #12 m_sda = b[i];
            pulse();
        end
        #12 m_sda = 1'b1;
        #24 m_scl = 1'b1;
        wait (scl === 1'b1);
        ack_seen = !sda;
        #24 m_scl = 1'b0;
    endtask
    // Data rises under a high clock
    task stop_cond();
        #12 m_sda = 1'b0;
        pulse();
        #24 m_scl = 1'b1;
        wait (scl === 1'b1);
        #24 m_sda = 1'b1;
    endtask
endmodule

// ---- tws_line_if.sv ----
// Synchronised line levels, edges and bus conditions shared inside the channel.
// Assumes one pclk domain for all parties of the interface.
`timescale 1ns/100ps
interface tws_line_if;
    import tws_pkg::*;
    logic [LN_W-1:0] lvl;
    logic [LN_W-1:0] rise;
    logic [LN_W-1:0] fall;
    logic pin_b;
    logic start_cond;
    logic stop_cond;
    modport sync (output lvl, output rise, output fall);
    modport cond (input lvl, input fall, input rise, input pin_b, output start_cond, output stop_cond);
    modport core (input lvl, input rise, input fall, input start_cond, input stop_cond, output pin_b);
endinterface

// ---- tws_pkg.sv ----
// Constants, register map and state types of the two-wire serial channel.
// Assumes a 200 MHz APB clock and an 8-bit APB byte address.
package tws_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int SCLK_HALF_NS = 1000;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DIV_W = 9;
    localparam logic [DIV_W-1:0] SCLK_HALF_LAST = DIV_W'(SCLK_HALF_CYC - 1);
    localparam logic [3:0] LAST_BIT = 4'h7;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TRIG = 8'h04;
    localparam logic [7:0] ADDR_SHIFT = 8'h08;
    localparam logic [7:0] ADDR_MATCH = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;

    // Control register fields
    localparam int CTRL_EN = 7;
    localparam int CTRL_AMATCH = 6;
    localparam int CTRL_WAKE = 5;
    localparam int CTRL_I2C = 4;
    localparam int CTRL_INTCLK = 3;
    localparam int CTRL_PINB = 2;
    localparam int CTRL_CLKLAT = 1;
    localparam int CTRL_ACKEN = 0;
    localparam logic [7:0] CTRL_WMASK = 8'hBF;

    // Trigger / detect register fields
    localparam int TRIG_REL = 0;
    localparam int TRIG_CMD = 1;
    localparam int TRIG_STOPD = 2;
    localparam int TRIG_COMMAND_DETECT = 3;
    localparam int TRIG_ACKD = 4;

    // Status register fields
    localparam int STAT_DONE = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_WAIT = 2;
    localparam int STAT_SEL = 3;
    localparam int STAT_DIR = 4;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SHIFT_RST = 8'hFF;
    localparam logic [7:0] MATCH_RST = 8'h00;

    // Line bit order in the synchroniser
    localparam int LN_SCL = 0;
    localparam int LN_SDA_A = 1;
    localparam int LN_SDA_B = 2;
    localparam int LN_W = 3;

    // Shift engine states
    typedef enum logic [1:0] {SH_IDLE, SH_DATA, SH_ACK, SH_HOLD} tws_shift_t;

endpackage

// ---- tws_sync.sv ----
// Two-flop synchroniser with edge detect for the clock and data pins.
// Assumes pins idle high through external pull-ups.
`timescale 1ns/100ps
module tws_sync import tws_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Raw pins and synchronised view
    input wire logic [LN_W-1:0] pins,
    tws_line_if.sync ln
);
    typedef struct packed {
        logic [LN_W-1:0] meta;
        logic [LN_W-1:0] lvl;
        logic [LN_W-1:0] prev;
    } tws_sync_t;

    tws_sync_t s;
    tws_sync_t next_s;

    ////////////////////////////////////////////////////////////////////////////
    // Next state: meta feeds only lvl
    always_comb begin
        next_s = s;
        next_s.meta = pins;
        next_s.lvl = s.meta;
        next_s.prev = s.lvl;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    // Levels and one-cycle edge pulses
    assign ln.lvl = s.lvl;
    assign ln.rise = s.lvl & ~s.prev;
    assign ln.fall = ~s.lvl & s.prev;
endmodule
